/* File: verilog/tvs_pkg.sv */
// Shared constants, types and address decode for the three-voice sound register bank.
package tvs_pkg;

    // ==========================================================
    // Address map
    localparam logic [15:0] BASE_ADDR      = 16'hd400;
    localparam int          NUM_VOICES     = 3;
    localparam logic [4:0]  VOICE_STRIDE   = 5'h07;
    localparam logic [4:0]  VOICE1_FIRST   = 5'h07;
    localparam logic [4:0]  VOICE2_FIRST   = 5'h0e;
    localparam logic [4:0]  VOICE_LIMIT    = 5'h15;
    localparam logic [4:0]  VOLUME_OFS     = 5'h18;

    // ==========================================================
    // Offsets inside one voice
    localparam logic [2:0]  OFS_FREQ_LOW   = 3'h0;
    localparam logic [2:0]  OFS_FREQ_HIGH  = 3'h1;
    localparam logic [2:0]  OFS_PULSE_LOW  = 3'h2;
    localparam logic [2:0]  OFS_PULSE_HIGH = 3'h3;
    localparam logic [2:0]  OFS_CONTROL    = 3'h4;
    localparam logic [2:0]  OFS_ATK_DECAY  = 3'h5;
    localparam logic [2:0]  OFS_SUS_REL    = 3'h6;

    // ==========================================================
    // Field positions and values
    localparam int          GATE_BIT       = 0;
    localparam logic [7:0]  NOISE_VALUE    = 8'h80;
    localparam logic [7:0]  REG_RESET      = 8'h00;
    localparam logic [7:0]  FULL_VOLUME    = 8'h0f;

    // ==========================================================
    // Types
    typedef struct packed {
        logic [7:0] freq_low;
        logic [7:0] freq_high;
        logic [7:0] pulse_low;
        logic [7:0] pulse_high;
        logic [7:0] control_gate;
        logic [7:0] attack_decay;
        logic [7:0] sustain_release;
    } tvs_voice_regs_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
        logic        wr;
        logic        rd;
    } tvs_bus_req_t;

    typedef struct packed {
        logic       voice_hit;
        logic [1:0] voice;
        logic [2:0] ofs;
        logic       volume_hit;
    } tvs_decode_t;

    // ==========================================================
    // Decode of a host address into voice, offset or volume.
    function automatic tvs_decode_t tvs_decode(input logic [15:0] addr);
        tvs_decode_t d;
        logic [15:0] rel;
        logic [4:0]  r5;
        d   = '0;
        rel = addr - BASE_ADDR;
        r5  = rel[4:0];
        if (addr >= BASE_ADDR && rel[15:5] == 11'h000) begin
            if (r5 < VOICE1_FIRST) begin
                d.voice_hit = 1'b1;
                d.voice     = 2'h0;
                d.ofs       = r5[2:0];
            end else if (r5 < VOICE2_FIRST) begin
                d.voice_hit = 1'b1;
                d.voice     = 2'h1;
                d.ofs       = 3'(r5 - VOICE1_FIRST);
            end else if (r5 < VOICE_LIMIT) begin
                d.voice_hit = 1'b1;
                d.voice     = 2'h2;
                d.ofs       = 3'(r5 - VOICE2_FIRST);
            end else if (r5 == VOLUME_OFS) begin
                d.volume_hit = 1'b1;
            end
        end
        return d;
    endfunction

    // Byte of a voice group selected by its offset.
    function automatic logic [7:0] tvs_pick(input tvs_voice_regs_t v, input logic [2:0] ofs);
        logic [7:0] b;
        b = 8'h00;
        unique case (ofs)
            OFS_FREQ_LOW:   b = v.freq_low;
            OFS_FREQ_HIGH:  b = v.freq_high;
            OFS_PULSE_LOW:  b = v.pulse_low;
            OFS_PULSE_HIGH: b = v.pulse_high;
            OFS_CONTROL:    b = v.control_gate;
            OFS_ATK_DECAY:  b = v.attack_decay;
            OFS_SUS_REL:    b = v.sustain_release;
            default:        b = 8'h00;
        endcase
        return b;
    endfunction

endpackage

/* File: verilog/tvs_voice.sv */
// Register group of one voice: frequency, pulse, control with gate, envelope.
`timescale 1ns/10ps
module tvs_voice
    import tvs_pkg::*;
(
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     wr_i,
    input  wire logic [2:0]               ofs_i,
    input  wire logic [7:0]               data_i,
    output tvs_pkg::tvs_voice_regs_t      regs_o
);

    tvs_voice_regs_t st;
    tvs_voice_regs_t next_st;

    // ==========================================================
    // Register update
    always_comb begin
        next_st = st;
        if (wr_i) begin
            unique case (ofs_i)
                // RULE_02 frequency byte pair
                OFS_FREQ_LOW:   next_st.freq_low        = data_i;
                OFS_FREQ_HIGH:  next_st.freq_high       = data_i;
                OFS_PULSE_LOW:  next_st.pulse_low       = data_i;
                OFS_PULSE_HIGH: next_st.pulse_high      = data_i;
                // RULE_03 control write gates voice
                OFS_CONTROL:    next_st.control_gate    = data_i;
                // RULE_06 envelope register pair
                OFS_ATK_DECAY:  next_st.attack_decay    = data_i;
                OFS_SUS_REL:    next_st.sustain_release = data_i;
                default:        next_st = st;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign regs_o = st;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_freq_low_byte: assert property ( // RULE_02
        wr_i && ofs_i == OFS_FREQ_LOW |=> st.freq_low == $past(data_i) && $stable(st.freq_high))
        else $error("Low frequency byte not stored alone.");

    chk_env_pair: assert property ( // RULE_06
        wr_i && (ofs_i == OFS_ATK_DECAY || ofs_i == OFS_SUS_REL)
        |=> ($past(ofs_i) == OFS_ATK_DECAY ? st.attack_decay : st.sustain_release)
            == $past(data_i))
        else $error("Envelope write was lost.");

endmodule

/* File: verilog/tvs_sound_regs.sv */
// Top of the three-voice sound register bank on the host memory bus.
`timescale 1ns/10ps
// ==========================================================
// How it works
// RULE_01 - Three independent voices, seven registers each.
// RULE_02 - Offsets 0 and 1 hold frequency low, high.
// RULE_03 - Control writes on value starts, off stops.
// RULE_04 - Register 24 is shared master volume.
// RULE_05 - Voices two, three at offsets 7, 14.
// RULE_06 - Offsets 5 and 6 hold envelope settings.
// RULE_07 - Register n sits at address 54272 plus n.
// RULE_08 - Host sets timbre through offsets 2 to 6.
// RULE_09 - Offsets 0 through 24 all accept writes; here writes to offsets 21 to 23 are ignored.
// RULE_10 - Frequency spans nine octaves, sixteen bits.
// RULE_11 - Control bit zero gates, upper bits pick waveform.
module tvs_sound_regs
    import tvs_pkg::*;
(
    input  wire logic                                CLOCK_I,
    input  wire logic                                SYS_RST_I,
    input  wire tvs_pkg::tvs_bus_req_t               BUS_I,
    output logic [7:0]                               BUS_RDATA_O,
    output logic                                     BUS_RVALID_O,
    output tvs_pkg::tvs_voice_regs_t [2:0]           VOICE_O,
    output logic [2:0]                               VOICE_GATE_O,
    output logic [2:0][15:0]                         VOICE_FREQ_O,
    output logic [7:0]                               MASTER_VOLUME_O
);

    typedef struct packed {
        logic [7:0] rd_data;
        logic       rd_valid;
        logic [7:0] master_volume;
    } tvs_top_state_t;

    tvs_top_state_t              st;
    tvs_top_state_t              next_st;
    tvs_decode_t                 dec;
    tvs_voice_regs_t [2:0]       voice_regs;
    logic [2:0]                  voice_wr;

    // ==========================================================
    // Address decode
    // RULE_07 window at fixed base
    assign dec = tvs_decode(BUS_I.addr);

    // ==========================================================
    // Voice groups
    // RULE_05 strided write steering
    // RULE_09 voice offsets 0 to 20 take writes
    always_comb begin
        for (int i = 0; i < NUM_VOICES; i++) begin
            voice_wr[i] = BUS_I.wr && dec.voice_hit && dec.voice == 2'(i);
        end
    end

    // RULE_01 three independent voice groups
    for (genvar g = 0; g < NUM_VOICES; g++) begin : g_voice
        tvs_voice u_voice (
            .clk_i  (CLOCK_I),
            .rst_i  (SYS_RST_I),
            .wr_i   (voice_wr[g]),
            .ofs_i  (dec.ofs),
            .data_i (BUS_I.data),
            .regs_o (voice_regs[g])
        );
        // RULE_11 gate is control bit zero
        assign VOICE_GATE_O[g] = voice_regs[g].control_gate[GATE_BIT];
        // RULE_10 full sixteen bit pitch word
        assign VOICE_FREQ_O[g] = {voice_regs[g].freq_high, voice_regs[g].freq_low};
    end

    assign VOICE_O = voice_regs;

    // ==========================================================
    // Volume and read-back
    // A read in the same cycle as a write returns the value held before that write.
    always_comb begin
        next_st          = st;
        next_st.rd_valid = 1'b0;
        // RULE_04 shared master volume
        if (BUS_I.wr && dec.volume_hit) begin
            next_st.master_volume = BUS_I.data;
        end
        if (BUS_I.rd) begin
            next_st.rd_valid = 1'b1;
            if (dec.voice_hit) begin
                next_st.rd_data = tvs_pick(voice_regs[dec.voice], dec.ofs);
            end else if (dec.volume_hit) begin
                next_st.rd_data = st.master_volume;
            end else begin
                next_st.rd_data = 8'h00;
            end
        end
    end

    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign BUS_RDATA_O     = st.rd_data;
    assign BUS_RVALID_O    = st.rd_valid;
    assign MASTER_VOLUME_O = st.master_volume;

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SYS_RST_I);

    chk_voice_indep: assert property ( // RULE_01
        BUS_I.wr && dec.voice_hit && dec.voice == 2'h2
        |=> $stable(voice_regs[0]) && $stable(voice_regs[1]))
        else $error("Write to third voice disturbed another voice.");

    chk_freq_high: assert property ( // RULE_02
        BUS_I.wr && BUS_I.addr == BASE_ADDR + 16'h0001
        |=> VOICE_FREQ_O[0][15:8] == $past(BUS_I.data))
        else $error("High frequency byte not at offset one.");

    chk_gate_start: assert property ( // RULE_03
        BUS_I.wr && BUS_I.addr == BASE_ADDR + 16'h0004 && BUS_I.data == 8'h41
        |=> VOICE_GATE_O[0] ##1 VOICE_GATE_O[0] || $past(voice_wr[0]))
        else $error("On value did not start first voice.");

    chk_gate_stop: assert property ( // RULE_03
        BUS_I.wr && BUS_I.addr == BASE_ADDR + 16'h0012 && BUS_I.data == 8'h40
        |=> !VOICE_GATE_O[2] && VOICE_O[2].control_gate[7:1] == 7'h20)
        else $error("Off value did not stop third voice.");

    chk_volume_write: assert property ( // RULE_04
        BUS_I.wr && BUS_I.addr == BASE_ADDR + 16'h0018
        |=> MASTER_VOLUME_O == $past(BUS_I.data) && $stable(voice_regs))
        else $error("Master volume write misplaced.");

    chk_voice_stride: assert property ( // RULE_05
        BUS_I.wr && BUS_I.addr == BASE_ADDR + 16'h000b
        |=> VOICE_O[1].control_gate == $past(BUS_I.data) && $stable(voice_regs[0]))
        else $error("Second voice control not at offset eleven.");

    chk_outside_base: assert property ( // RULE_07
        BUS_I.wr && (BUS_I.addr < BASE_ADDR || BUS_I.addr > BASE_ADDR + 16'h0018)
        |=> $stable(voice_regs) && $stable(MASTER_VOLUME_O))
        else $error("Write outside the register window took effect.");

    chk_readback: assert property ( // RULE_09
        BUS_I.wr && dec.voice_hit ##1 BUS_I.rd && $stable(BUS_I.addr) && !BUS_I.wr
        |=> BUS_RVALID_O && BUS_RDATA_O == $past(BUS_I.data, 2))
        else $error("Written register did not read back.");

    chk_freq_span: assert property ( // RULE_10
        BUS_I.wr && BUS_I.addr == BASE_ADDR + 16'h000e && BUS_I.data == 8'hff
        ##1 BUS_I.wr && BUS_I.addr == BASE_ADDR + 16'h000f && BUS_I.data == 8'hff
        |=> VOICE_FREQ_O[2] == 16'hffff)
        else $error("Frequency word does not reach full span.");

    chk_noise_select: assert property ( // RULE_11
        BUS_I.wr && BUS_I.addr == BASE_ADDR + 16'h0004 && BUS_I.data == NOISE_VALUE
        |=> !VOICE_GATE_O[0] && VOICE_O[0].control_gate[7])
        else $error("Noise value not held with gate low.");

    // ==========================================================
    // Read path and remaining map checks
    // These compare against the register outputs and host addresses, not the
    // internal decode, so a fault in the decode cannot vouch for itself.

    chk_rvalid_rise: assert property ( // RULE_09
        BUS_I.rd |=> BUS_RVALID_O)
        else $error("Read was not answered in the next cycle.");

    chk_rvalid_drop: assert property ( // RULE_09
        !BUS_I.rd |=> !BUS_RVALID_O)
        else $error("Read valid stood without a read.");

    chk_read_outside: assert property ( // RULE_07
        BUS_I.rd && (BUS_I.addr < BASE_ADDR || BUS_I.addr > BASE_ADDR + 16'h0018)
        |=> BUS_RDATA_O == 8'h00)
        else $error("Read outside the register window returned data.");

    chk_hole_ignored: assert property ( // RULE_05
        BUS_I.wr && BUS_I.addr >= BASE_ADDR + 16'h0015 && BUS_I.addr <= BASE_ADDR + 16'h0017
        |=> $stable(voice_regs) && $stable(MASTER_VOLUME_O))
        else $error("Write to an unused offset took effect.");

    chk_volume_read: assert property ( // RULE_04
        BUS_I.rd && BUS_I.addr == BASE_ADDR + 16'h0018
        |=> BUS_RDATA_O == $past(MASTER_VOLUME_O))
        else $error("Volume read-back differs from the volume output.");

    chk_volume_held: assert property ( // RULE_04
        !(BUS_I.wr && BUS_I.addr == BASE_ADDR + 16'h0018)
        |=> $stable(MASTER_VOLUME_O))
        else $error("Master volume changed without its own write.");

    chk_last_reg: assert property ( // RULE_09
        BUS_I.wr && BUS_I.addr == BASE_ADDR + 16'h0014
        |=> VOICE_O[2].sustain_release == $past(BUS_I.data))
        else $error("Last voice register did not take its write.");

    chk_env_third: assert property ( // RULE_06
        BUS_I.wr && BUS_I.addr == BASE_ADDR + 16'h0013
        |=> VOICE_O[2].attack_decay == $past(BUS_I.data))
        else $error("Third voice envelope write misplaced.");

    chk_read_old: assert property ( // RULE_09
        BUS_I.wr && BUS_I.rd && BUS_I.addr == BASE_ADDR + 16'h0013
        |=> BUS_RDATA_O == $past(VOICE_O[2].attack_decay))
        else $error("Read beside a write did not return the old byte.");

    chk_pulse_second: assert property ( // RULE_05
        BUS_I.wr && BUS_I.addr == BASE_ADDR + 16'h0009
        |=> VOICE_O[1].pulse_low == $past(BUS_I.data))
        else $error("Second voice pulse byte not at offset nine.");

    chk_gate_second: assert property ( // RULE_03
        BUS_I.wr && BUS_I.addr == BASE_ADDR + 16'h000b && BUS_I.data[GATE_BIT]
        |=> VOICE_GATE_O[1])
        else $error("On value did not start second voice.");

    chk_freq_low_third: assert property ( // RULE_02
        BUS_I.wr && BUS_I.addr == BASE_ADDR + 16'h000e
        |=> VOICE_FREQ_O[2][7:0] == $past(BUS_I.data) && $stable(VOICE_FREQ_O[2][15:8]))
        else $error("Third voice low frequency byte misplaced.");

endmodule

/* File: verification/tvs_host_model.sv */
// Host processor model that drives write and read cycles on the register bank bus.
`timescale 1ns/10ps
module tvs_host_model
    import tvs_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rvalid_i,
    input  wire logic [7:0]           rdata_i,
    output tvs_pkg::tvs_bus_req_t     bus_o
);
    // ==========================================================
    // Idle bus
    // Released lines show the inverse of their last value, so a design that
    // samples address or data without a strobe cannot match by luck.
    task automatic release_bus();
        bus_o.addr = ~bus_o.addr;
        bus_o.data = ~bus_o.data;
        bus_o.wr   = 1'b0;
        bus_o.rd   = 1'b0;
    endtask

    initial begin
        bus_o = '0;
    end

    // ==========================================================
    // Bus cycles
    // Each request is raised at a falling edge and held across one rising edge.
    // host writes registers.
    task automatic write_cycle(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_i);
        bus_o = '{addr: a, data: d, wr: 1'b1, rd: 1'b0};
        @(negedge clk_i);
        release_bus();
    endtask

    task automatic read_cycle(input logic [15:0] a, output logic [7:0] d, output logic ok);
        @(negedge clk_i);
        bus_o = '{addr: a, data: bus_o.data, wr: 1'b0, rd: 1'b1};
        @(negedge clk_i);
        d  = rdata_i;
        ok = rvalid_i;
        release_bus();
    endtask

    // Two writes in consecutive cycles, the strobe held high across both edges.
    task automatic write_pair(input logic [15:0] a0, input logic [7:0] d0,
                              input logic [15:0] a1, input logic [7:0] d1);
        @(negedge clk_i);
        bus_o = '{addr: a0, data: d0, wr: 1'b1, rd: 1'b0};
        @(negedge clk_i);
        bus_o = '{addr: a1, data: d1, wr: 1'b1, rd: 1'b0};
        @(negedge clk_i);
        release_bus();
    endtask

    // A write, then a read of the same address in the very next cycle.
    task automatic write_then_read(input logic [15:0] a, input logic [7:0] d,
                                   output logic [7:0] q, output logic ok);
        @(negedge clk_i);
        bus_o = '{addr: a, data: d, wr: 1'b1, rd: 1'b0};
        @(negedge clk_i);
        bus_o = '{addr: a, data: d, wr: 1'b0, rd: 1'b1};
        @(negedge clk_i);
        q  = rdata_i;
        ok = rvalid_i;
        release_bus();
    endtask

    // Write and read raised together; the read answers with the byte held before.
    task automatic write_read_same(input logic [15:0] a, input logic [7:0] d,
                                   output logic [7:0] q, output logic ok);
        @(negedge clk_i);
        bus_o = '{addr: a, data: d, wr: 1'b1, rd: 1'b1};
        @(negedge clk_i);
        q  = rdata_i;
        ok = rvalid_i;
        release_bus();
    endtask
endmodule

/* File: verification/tvs_sound_regs_bench.sv */
// Self-checking bench of the three-voice sound register bank.
`timescale 1ns/10ps
`define CHK(got, want) begin n_tests++; if ((got) !== (want)) begin err_total++; \
    $display("[ERR] %0t got %h want %h", $time, got, want); end end
module tvs_sound_regs_bench;
    import tvs_pkg::*;
    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    tvs_bus_req_t          bus;
    logic [7:0]            rdata;
    logic                  rvalid;
    tvs_voice_regs_t [2:0] voice;
    logic [2:0]            gate;
    logic [2:0][15:0]      freq;
    logic [7:0]            vol;
    logic [7:0]            exp_reg [0:24];
    int                    err_total = 0;
    int                    n_tests = 0;
    int                    cycles = 0;

    always #2 clk = ~clk;

    tvs_sound_regs DUT (.CLOCK_I(clk), .SYS_RST_I(rst), .BUS_I(bus), .BUS_RDATA_O(rdata),
        .BUS_RVALID_O(rvalid), .VOICE_O(voice), .VOICE_GATE_O(gate), .VOICE_FREQ_O(freq),
        .MASTER_VOLUME_O(vol));
    tvs_host_model HOST (.clk_i(clk), .rvalid_i(rvalid), .rdata_i(rdata), .bus_o(bus));

    // ==========================================================
    // Shared checks
    function automatic logic mapped(input int ofs);
        return (ofs >= 0 && ofs <= 20) || ofs == 24;
    endfunction

    task automatic check_all();
        tvs_voice_regs_t w;
        for (int v = 0; v < 3; v++) begin
            for (int k = 0; k < 7; k++) begin
                w[55-8*k -: 8] = exp_reg[7*v+k];
            end
            `CHK(voice[v], w)
            `CHK(freq[v], {exp_reg[7*v+1], exp_reg[7*v]})
            `CHK(gate[v], exp_reg[7*v+4][0])
        end
        `CHK(vol, exp_reg[24])
    endtask

    task automatic put(input int ofs, input logic [7:0] d);
        HOST.write_cycle(BASE_ADDR + 16'(ofs), d);
        if (mapped(ofs)) begin
            exp_reg[ofs] = d;
        end
        check_all();
    endtask

    task automatic get(input int ofs);
        logic [7:0] d;
        logic       ok;
        HOST.read_cycle(BASE_ADDR + 16'(ofs), d, ok);
        `CHK(ok, 1'b1)
        `CHK(d, mapped(ofs) ? exp_reg[ofs] : 8'h00)
        @(negedge clk);
        `CHK(rvalid, 1'b0)
    endtask

    // ==========================================================
    // Scenarios
    // Reset leaves every register clear, then the host zero fill must hold it so.
    task automatic t_init();
        for (int n = 0; n < 25; n++) begin
            exp_reg[n] = 8'h00;
        end
        check_all();
        for (int n = 0; n < 25; n++) begin
            put(n, 8'h00);
        end
    endtask

    // Distinct bytes everywhere, including the holes at 21 to 23 and just outside.
    task automatic t_map();
        for (int n = -1; n < 26; n++) begin
            put(n, 8'(n * 37 + 5));
        end
        for (int n = -1; n < 26; n++) begin
            get(n);
        end
    endtask

    // Every control pair on every voice; other voices must not follow.
    task automatic t_gate();
        logic [7:0] on_val [4] = '{8'h41, 8'h11, 8'h21, 8'h81};
        for (int v = 0; v < 3; v++) begin
            put(7 * v + 2, 8'hff);
            put(7 * v + 3, 8'h00);
            for (int k = 0; k < 4; k++) begin
                put(7 * v + 4, on_val[k]);
                put(7 * v + 4, on_val[k] - 8'h01);
            end
        end
    endtask

    // Full volume and the sixteen-bit pitch word at its top, then with its high byte cleared.
    task automatic t_level();
        put(24, FULL_VOLUME);
        for (int v = 0; v < 3; v++) begin
            put(7 * v, 8'hff);
            put(7 * v + 1, 8'hff);
            put(7 * v + 1, 8'h00);
        end
        get(24);
    endtask

    // Back-to-back traffic: a pitch word in two consecutive writes, a read right
    // after a write, and a write and read together, which must see the old byte.
    task automatic t_pairs();
        logic [7:0] d;
        logic       ok;
        HOST.write_pair(BASE_ADDR + 16'(14), 8'hff, BASE_ADDR + 16'(15), 8'hff);
        exp_reg[14] = 8'hff;
        exp_reg[15] = 8'hff;
        check_all();
        HOST.write_then_read(BASE_ADDR + 16'(19), 8'h5a, d, ok);
        exp_reg[19] = 8'h5a;
        `CHK(ok, 1'b1)
        `CHK(d, exp_reg[19])
        HOST.write_read_same(BASE_ADDR + 16'(19), 8'ha5, d, ok);
        `CHK(ok, 1'b1)
        `CHK(d, exp_reg[19])
        exp_reg[19] = 8'ha5;
        check_all();
    endtask

    // ==========================================================
    // Verdict and watchdog
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // The run needs some 280 cycles; a hung bus stops here.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        t_init();
        t_map();
        t_gate();
        t_level();
        t_pairs();
        tally_and_finish();
    end
endmodule
